// ==== logic/usb_link_timing.sv ====
// usb link gap timing, response timeouts and test modes
//
// Contract
// - ls/fs device response gap at least two bits
// - detachable ls/fs device responds within 6.5 bits
// - captive ls/fs device responds under 7.5 bits
// - hs sender waits eight idle bits after receive
// - hs device responds within 192 bits
// - ls/fs timeout between 16 and 18 bits
// - hs timeout between 736 and 816 bits
// - nak mode holds transceiver in hs receive
// - nak mode upstream naks good in tokens
// - constant j mode drives j
// - constant k mode drives k
// - packet mode repeats fixed test packet
// - test packet gap minimum to 125 us
// - force enable downstream port, repeat, disconnect flag
// - test requests accepted only when hs capable
// - test mode entered within 3 ms of status
// - test mode left only by power cycle or hub reset
`timescale 1ns/100ps
`include "usb_timing_consts.svh"

module usb_link_timing #(
  parameter int TP_GAP = `TP_GAP_BITS,
  parameter int PKT_GAP_MAX_CYC = `TP_GAP_MAX_US * `CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic srst,
  input usb_timing_pkg::speed_t speed,
  input wire logic bitStrobe,
  input wire logic captiveCable,
  input wire logic hsCapable,
  input wire logic upstreamPort,
  input wire logic hubReset,
  input usb_timing_pkg::line_evt_t lineEvt,
  input usb_timing_pkg::tx_word_t txIn,
  input wire logic txInValid,
  output logic txInReady,
  output usb_timing_pkg::tx_word_t txOut,
  output logic txOutValid,
  input wire logic txOutReady,
  output logic nakReq,
  output logic rspLate,
  output logic rspTimeout,
  input wire logic testReq,
  input usb_timing_pkg::test_sel_t testSel,
  input wire logic statusDone,
  output usb_timing_pkg::test_sel_t testMode,
  output logic xcvrHsRx,
  output logic driveJ,
  output logic driveK,
  output logic pktBit,
  output logic pktBitValid,
  output logic portForceEn,
  output logic repeatEn,
  input wire logic discIn,
  output logic discFlag
);
  import usb_timing_pkg::*;

  logic [`GAP_W-1:0] gapCnt_ff;
  logic rxBusy_ff;
  logic inPkt_ff;
  logic waitRsp_ff;
  logic nakPend_ff;
  logic nakReq_ff;
  logic rspLate_ff;
  logic rspTimeout_ff;
  logic discFlag_ff;
  logic armed_ff;
  test_sel_t armSel_ff;
  test_sel_t testMode_ff;
  logic [`GAP_W-1:0] minGap;
  logic [`GAP_W-1:0] rspMax;
  logic [`GAP_W-1:0] toLimit;
  logic gateOpen;
  logic normalTx;
  logic txGo;
  logic bufValid;
  logic bufReady;
  logic sopOut;
  logic eopOut;
  logic nakFire;
  logic selOk;
  logic toFire;
  tx_word_t bufWord;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // ----------------------------------------
  // speed dependent limits
  // ----------------------------------------
  always_comb
  begin
    if (speed == SPD_HS)
    begin
      minGap = `HS_MIN_GAP;
      rspMax = `HS_RSP_MAX;
      toLimit = `HS_TO;
    end
    else
    begin
      minGap = `LSFS_MIN_GAP;
      rspMax = captiveCable ? `LSFS_RSP_CAP : `LSFS_RSP_DET;
      toLimit = `LSFS_TO;
    end
  end

  // ----------------------------------------
  // transmit path through the buffer
  // ----------------------------------------
  two_entry_buf #(
    .W($bits(tx_word_t))
  ) txBuf (
    .sys_clk(sys_clk),
    .srst(srst),
    .inData(txIn),
    .inValid(txInValid),
    .inReady(txInReady),
    .outData(bufWord),
    .outValid(bufValid),
    .outReady(bufReady)
  );

  assign normalTx = (testMode_ff == TM_NONE) || (testMode_ff == TM_SE0_NAK) ||
    (testMode_ff == TM_FORCE_EN);
  assign gateOpen = !rxBusy_ff && (gapCnt_ff >= minGap);
  assign txGo = inPkt_ff || (gateOpen && normalTx && !nakPend_ff);
  assign txOutValid = bufValid && txGo;
  assign bufReady = txOutReady && txGo;
  assign txOut = bufWord;
  assign sopOut = txOutValid && txOutReady && !inPkt_ff;
  assign eopOut = txOutValid && txOutReady && bufWord.last;
  assign nakFire = nakPend_ff && gateOpen && !inPkt_ff;

  // ----------------------------------------
  // packet in progress on our side
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      inPkt_ff <= 1'b0;
    else if (eopOut)
      inPkt_ff <= 1'b0;
    else if (sopOut)
      inPkt_ff <= 1'b1;
  end

  // ----------------------------------------
  // received packet in progress
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rxBusy_ff <= 1'b0;
    else if (lineEvt.eop)
      rxBusy_ff <= 1'b0;
    else if (lineEvt.sop)
      rxBusy_ff <= 1'b1;
  end

  // ----------------------------------------
  // idle bit times since last end of packet
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      gapCnt_ff <= `GAP_SAT;
    else if (lineEvt.eop || eopOut || nakReq_ff)
      gapCnt_ff <= '0;
    else if (bitStrobe && !rxBusy_ff && !inPkt_ff && gapCnt_ff != `GAP_SAT)
      gapCnt_ff <= gapCnt_ff + 10'h001;
  end

  // ----------------------------------------
  // late response flag
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rspLate_ff <= 1'b0;
    else
      rspLate_ff <= sopOut && bufWord.isRsp && (gapCnt_ff > rspMax);
  end

  // ----------------------------------------
  // response wait and timeout
  // ----------------------------------------
  assign toFire = waitRsp_ff && !lineEvt.sop && !rxBusy_ff && (gapCnt_ff >= toLimit);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      waitRsp_ff <= 1'b0;
    else if (eopOut && bufWord.wantRsp)
      waitRsp_ff <= 1'b1;
    else if (lineEvt.sop || toFire)
      waitRsp_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rspTimeout_ff <= 1'b0;
    else
      rspTimeout_ff <= toFire;
  end

  // ----------------------------------------
  // test mode request and entry
  // ----------------------------------------
  always_comb
  begin
    selOk = 1'b0;
    if (hsCapable)
    begin
      case (testSel)
        TM_SE0_NAK, TM_J, TM_K, TM_PACKET: selOk = 1'b1;
        TM_FORCE_EN: selOk = !upstreamPort;
        default: selOk = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      armed_ff <= 1'b0;
      armSel_ff <= TM_NONE;
    end
    else if (testMode_ff != TM_NONE)
      armed_ff <= 1'b0;
    else if (testReq)
    begin
      armed_ff <= selOk;
      armSel_ff <= testSel;
    end
    else if (statusDone)
      armed_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      testMode_ff <= TM_NONE;
    else if (hubReset && !upstreamPort)
      testMode_ff <= TM_NONE;
    else if (testMode_ff == TM_NONE && armed_ff && statusDone)
      testMode_ff <= armSel_ff;
  end

  // ----------------------------------------
  // nak answer in receive test mode
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      nakPend_ff <= 1'b0;
    else if (testMode_ff == TM_SE0_NAK && upstreamPort && lineEvt.inTokOk)
      nakPend_ff <= 1'b1;
    else if (nakFire)
      nakPend_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      nakReq_ff <= 1'b0;
    else
      nakReq_ff <= nakFire;
  end

  // ----------------------------------------
  // line state and port controls
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      discFlag_ff <= 1'b0;
    else
      discFlag_ff <= discIn;
  end

  assign xcvrHsRx = (testMode_ff == TM_SE0_NAK);
  assign driveJ = (testMode_ff == TM_J);
  assign driveK = (testMode_ff == TM_K);
  assign portForceEn = (testMode_ff == TM_FORCE_EN);
  assign repeatEn = portForceEn && rxBusy_ff;
  assign testMode = testMode_ff;
  assign nakReq = nakReq_ff;
  assign rspLate = rspLate_ff;
  assign rspTimeout = rspTimeout_ff;
  assign discFlag = discFlag_ff;

  test_pkt_gen #(
    .GAP_BITS(TP_GAP),
    .GAP_MAX_CYC(PKT_GAP_MAX_CYC)
  ) pktGen (
    .sys_clk(sys_clk),
    .srst(srst),
    .enable(testMode_ff == TM_PACKET),
    .bitStrobe(bitStrobe),
    .pktBit(pktBit),
    .pktBitValid(pktBitValid)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  lsGap_a: assert property (
    sopOut && speed != SPD_HS |-> gapCnt_ff >= `LSFS_MIN_GAP)
    else $error("ls fs gap too short");
  hsGap_a: assert property (
    (sopOut || nakFire) && speed == SPD_HS |-> gapCnt_ff >= `HS_MIN_GAP && !rxBusy_ff)
    else $error("hs gap too short");
  lateDet_a: assert property (
    sopOut && bufWord.isRsp && speed != SPD_HS && !captiveCable &&
    gapCnt_ff > `LSFS_RSP_DET |=> rspLate_ff)
    else $error("late detachable response not flagged");
  lateCap_a: assert property (
    sopOut && bufWord.isRsp && speed != SPD_HS && captiveCable &&
    gapCnt_ff <= `LSFS_RSP_CAP |=> !rspLate_ff)
    else $error("captive response wrongly flagged");
  lateHs_a: assert property (
    sopOut && bufWord.isRsp && speed == SPD_HS && gapCnt_ff > `HS_RSP_MAX |=> rspLate_ff)
    else $error("late hs response not flagged");
  timeoutLs_a: assert property (
    rspTimeout_ff && $past(speed) != SPD_HS |->
    $past(gapCnt_ff) >= `LSFS_TO_LO && $past(gapCnt_ff) < `LSFS_TO_HI)
    else $error("ls fs timeout outside window");
  timeoutHs_a: assert property (
    rspTimeout_ff && $past(speed) == SPD_HS |->
    $past(gapCnt_ff) >= `HS_TO_LO && $past(gapCnt_ff) < `HS_TO_HI)
    else $error("hs timeout outside window");
  hsRxHold_a: assert property (
    testMode_ff == TM_SE0_NAK && !(hubReset && !upstreamPort) |->
    xcvrHsRx && !driveJ && !driveK ##1 xcvrHsRx)
    else $error("receive test mode lost");
  nakOnly_a: assert property (
    nakReq_ff |-> $past(testMode_ff) == TM_SE0_NAK && upstreamPort)
    else $error("nak outside receive test mode");
  constJ_a: assert property (
    testMode_ff == TM_J |-> driveJ && !driveK && !txOutValid)
    else $error("constant j not held");
  constK_a: assert property (
    testMode_ff == TM_K |-> driveK && !driveJ && !txOutValid)
    else $error("constant k not held");
  forceDown_a: assert property (
    portForceEn |-> !upstreamPort)
    else $error("force enable on upstream port");
  entry_a: assert property (
    testMode_ff == TM_NONE && armed_ff && statusDone && !(hubReset && !upstreamPort)
    |=> testMode_ff == $past(armSel_ff))
    else $error("test mode not entered");
  sticky_a: assert property (
    testMode_ff != TM_NONE && !(hubReset && !upstreamPort) |=> $stable(testMode_ff))
    else $error("test mode left without exit action");

endmodule : usb_link_timing

// ==== logic/usb_timing_consts.svh ====
// timing counts and test packet constants for the usb link timing block
`ifndef USB_TIMING_CONSTS_SVH
`define USB_TIMING_CONSTS_SVH

// ----------------------------------------
// bit time gaps and limits
// ----------------------------------------
`define GAP_W 10
`define GAP_SAT 10'h3FF
`define LSFS_MIN_GAP 10'h002
`define HS_MIN_GAP 10'h008
`define LSFS_RSP_DET 10'h006
`define LSFS_RSP_CAP 10'h007
`define HS_RSP_MAX 10'h0C0
`define LSFS_TO_LO 10'h010
`define LSFS_TO 10'h011
`define LSFS_TO_HI 10'h012
`define HS_TO_LO 10'h2E0
`define HS_TO 10'h308
`define HS_TO_HI 10'h330

// ----------------------------------------
// clock and real times
// ----------------------------------------
`define CLK_MHZ 100
`define TP_GAP_MAX_US 125
`define TP_GAP_BITS 88

// ----------------------------------------
// test packet, first bit sent is the msb
// ----------------------------------------
`define TPKT_W 9
`define TPKT_TOP 9'h1E7
`define TPKT_BITS { \
  112'h0000_0001_C300_0000_0000_0000_0000, \
  128'h5555_5555_5555_5555_7777_7777_7777_7777, \
  248'h7FFF_FFFF_FFFF_FFFF_FFFF_FFFF_FEFD_FBF7_EFDF_BF3F_7EFD_FBF7_EFDF_BF7E_6D73_7F}

`endif

// ==== logic/usb_timing_pkg.sv ====
// types shared by the usb link timing block
package usb_timing_pkg;

  typedef enum logic [1:0] {
    SPD_LS = 2'h0,
    SPD_FS = 2'h1,
    SPD_HS = 2'h2
  } speed_t;

  typedef enum logic [2:0] {
    TM_NONE = 3'h0,
    TM_SE0_NAK = 3'h1,
    TM_J = 3'h2,
    TM_K = 3'h3,
    TM_PACKET = 3'h4,
    TM_FORCE_EN = 3'h5
  } test_sel_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic isRsp;
    logic wantRsp;
  } tx_word_t;

  typedef struct packed {
    logic sop;
    logic eop;
    logic inTokOk;
  } line_evt_t;

endpackage : usb_timing_pkg

// ==== logic/two_entry_buf.sv ====
// two entry flip-flop buffer with valid and ready on both sides
`timescale 1ns/100ps

module two_entry_buf #(
  parameter int W = 11
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [W-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [W-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  logic [W-1:0] mem_ff [2];
  logic wrPtr_ff;
  logic rdPtr_ff;
  logic [1:0] cnt_ff;
  logic push;
  logic pop;

  assign inReady = (cnt_ff != 2'h2);
  assign outValid = (cnt_ff != 2'h0);
  assign outData = mem_ff[rdPtr_ff];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end

  // ----------------------------------------
  // pointers and fill count
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wrPtr_ff <= 1'b0;
      rdPtr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end
    else
    begin
      if (push)
        wrPtr_ff <= !wrPtr_ff;
      if (pop)
        rdPtr_ff <= !rdPtr_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : two_entry_buf

// ==== logic/test_pkt_gen.sv ====
// repeating test packet bit source
`timescale 1ns/100ps
`include "usb_timing_consts.svh"

module test_pkt_gen #(
  parameter int GAP_BITS = `TP_GAP_BITS,
  parameter int GAP_MAX_CYC = `TP_GAP_MAX_US * `CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic bitStrobe,
  output logic pktBit,
  output logic pktBitValid
);

  localparam logic [487:0] PKT = `TPKT_BITS;

  logic [`TPKT_W-1:0] idx_ff;
  logic sending_ff;
  logic [7:0] gap_ff;
  logic [31:0] gapCyc_ff;
  logic pktBit_ff;
  logic pktBitValid_ff;

  assign pktBit = pktBit_ff;
  assign pktBitValid = pktBitValid_ff;

  // ----------------------------------------
  // packet bits then idle gap, repeated
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst || !enable)
    begin
      idx_ff <= `TPKT_TOP;
      sending_ff <= 1'b1;
      gap_ff <= 8'h00;
      pktBit_ff <= 1'b0;
      pktBitValid_ff <= 1'b0;
    end
    else
    begin
      pktBitValid_ff <= bitStrobe && sending_ff;
      if (bitStrobe && sending_ff)
      begin
        pktBit_ff <= PKT[idx_ff];
        idx_ff <= idx_ff - 9'h001;
        if (idx_ff == 9'h000)
        begin
          sending_ff <= 1'b0;
          gap_ff <= 8'h00;
        end
      end
      else if (bitStrobe)
      begin
        gap_ff <= gap_ff + 8'h01;
        if (gap_ff == 8'(GAP_BITS - 1))
        begin
          sending_ff <= 1'b1;
          idx_ff <= `TPKT_TOP;
        end
      end
    end
  end

  // ----------------------------------------
  // gap length in clocks, checked only
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst || !enable || sending_ff)
      gapCyc_ff <= 32'h0000_0000;
    else
      gapCyc_ff <= gapCyc_ff + 32'h0000_0001;
  end

  gapMax_a: assert property (@(posedge sys_clk) disable iff (srst)
    gapCyc_ff <= 32'(GAP_MAX_CYC)) else $error("test packet gap too long");

  gapMin_a: assert property (@(posedge sys_clk) disable iff (srst)
    enable && $rose(sending_ff) |-> $past(gap_ff) == 8'(GAP_BITS - 1))
    else $error("test packet gap too short");

endmodule : test_pkt_gen

// ==== sim/usb_host_model.sv ====
// host side model facing the link timing block
`timescale 1ns/100ps

module usb_host_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic stall,
  input wire logic pktReq,
  input wire logic tokReq,
  input usb_timing_pkg::tx_word_t txOut,
  input wire logic txOutValid,
  output logic txOutReady,
  output usb_timing_pkg::line_evt_t lineEvt,
  output logic [7:0] wordCount,
  output logic [7:0] lastData
);
  import usb_timing_pkg::*;

  logic eopDue_ff;
  logic tokDue_ff;

  // ----------------
  // host packets
  // ----------------
  always_ff @(posedge sys_clk)
  begin
    eopDue_ff <= !srst && (pktReq || tokReq);
    tokDue_ff <= !srst && tokReq;
    lineEvt.sop <= !srst && (pktReq || tokReq);
    lineEvt.eop <= eopDue_ff;
    lineEvt.inTokOk <= tokDue_ff;
  end

  // ----------------
  // word sink with stall
  // ----------------
  always_ff @(posedge sys_clk)
  begin
    txOutReady <= !srst && !stall;
    if (srst)
    begin
      wordCount <= 8'h00;
      lastData <= 8'h00;
    end
    else if (txOutValid && txOutReady)
    begin
      wordCount <= wordCount + 8'h01;
      lastData <= txOut.data;
    end
  end
endmodule : usb_host_model

// ==== sim/tb_top.sv ====
// self-checking bench for the usb link timing block
`timescale 1ns/100ps

module tb_top;
  import usb_timing_pkg::*;

  localparam int WATCH_NS = 200000;
  logic sys_clk, srst, bitStrobe, captiveCable, hsCapable, upstreamPort, hubReset;
  speed_t speed;
  line_evt_t lineEvt;
  tx_word_t txIn, txOut;
  logic txInValid, txInReady, txOutValid, txOutReady, nakReq, rspLate, rspTimeout;
  logic testReq, statusDone, xcvrHsRx, driveJ, driveK, pktBit, pktBitValid;
  logic portForceEn, repeatEn, discIn, discFlag, stall, pktReq, tokReq;
  test_sel_t testSel, testMode;
  logic [7:0] wordCount, lastData;
  logic [39:0] pktSr;
  int toCnt, lateCnt, nakCnt, repCnt, nFail, totalChecks;
  int lateTab[6][4] = '{'{1,0,6,0}, '{1,0,7,1}, '{0,1,7,0}, '{0,1,8,1}, '{2,0,192,0},
    '{2,0,193,1}};
  int toTab[2][3] = '{'{1,16,1}, '{2,736,80}};
  int gapTab[2][2] = '{'{1,2}, '{2,8}};

  usb_link_timing #(.TP_GAP(8)) dut (.sys_clk(sys_clk), .srst(srst), .speed(speed),
    .bitStrobe(bitStrobe), .captiveCable(captiveCable), .hsCapable(hsCapable),
    .upstreamPort(upstreamPort), .hubReset(hubReset), .lineEvt(lineEvt), .txIn(txIn),
    .txInValid(txInValid), .txInReady(txInReady), .txOut(txOut), .txOutValid(txOutValid),
    .txOutReady(txOutReady), .nakReq(nakReq), .rspLate(rspLate), .rspTimeout(rspTimeout),
    .testReq(testReq), .testSel(testSel), .statusDone(statusDone), .testMode(testMode),
    .xcvrHsRx(xcvrHsRx), .driveJ(driveJ), .driveK(driveK), .pktBit(pktBit),
    .pktBitValid(pktBitValid), .portForceEn(portForceEn), .repeatEn(repeatEn),
    .discIn(discIn), .discFlag(discFlag));

  usb_host_model host (.sys_clk(sys_clk), .srst(srst), .stall(stall), .pktReq(pktReq),
    .tokReq(tokReq), .txOut(txOut), .txOutValid(txOutValid), .txOutReady(txOutReady),
    .lineEvt(lineEvt), .wordCount(wordCount), .lastData(lastData));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------
  // pulse counters and bit capture
  // ----------------
  always @(posedge sys_clk)
  begin
    toCnt <= toCnt + int'(rspTimeout === 1'b1);
    lateCnt <= lateCnt + int'(rspLate === 1'b1);
    nakCnt <= nakCnt + int'(nakReq === 1'b1);
    repCnt <= repCnt + int'(repeatEn === 1'b1);
    if (pktBitValid === 1'b1)
      pktSr <= {pktSr[38:0], pktBit};
  end

  // ----------------
  // access tasks
  // ----------------
  task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
    totalChecks++;
    if (got !== exp)
    begin
      nFail++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  task automatic strobe(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      bitStrobe <= 1'b1;
      @(posedge sys_clk);
      bitStrobe <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : strobe

  task automatic clr();
    toCnt = 0;
    lateCnt = 0;
    nakCnt = 0;
    repCnt = 0;
  endtask : clr

  task automatic do_reset();
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : do_reset

  task automatic push(input logic [7:0] d, input logic lst, input logic want, input logic rsp);
    int k;
    k = 0;
    @(posedge sys_clk);
    txIn <= '{data: d, last: lst, isRsp: rsp, wantRsp: want};
    txInValid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (txInReady !== 1'b1 && k < 50);
    txInValid <= 1'b0;
  endtask : push

  task automatic host_pkt(input logic tok);
    @(posedge sys_clk);
    pktReq <= !tok;
    tokReq <= tok;
    @(posedge sys_clk);
    pktReq <= 1'b0;
    tokReq <= 1'b0;
    strobe(0);
  endtask : host_pkt

  task automatic enter(input test_sel_t sel, input logic up, input logic hs);
    @(posedge sys_clk);
    upstreamPort <= up;
    hsCapable <= hs;
    testReq <= 1'b1;
    testSel <= sel;
    @(posedge sys_clk);
    testReq <= 1'b0;
    statusDone <= 1'b1;
    @(posedge sys_clk);
    statusDone <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : enter

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #(WATCH_NS);
    nFail++;
    $display("Error watchdog expected end seen hang");
    tally_and_finish();
  end

  // ----------------
  // tests
  // ----------------
  initial
  begin
    srst = 1'b1;
    speed = SPD_FS;
    {bitStrobe, captiveCable, hsCapable, upstreamPort, hubReset} = 5'h00;
    {txInValid, testReq, statusDone, discIn, stall, pktReq, tokReq} = 7'h00;
    txIn = '0;
    testSel = TM_NONE;
    pktSr = 40'h00_0000_0000;
    {toCnt, lateCnt, nakCnt, repCnt, nFail, totalChecks} = '0;
    do_reset();
    check("testMode", TM_NONE, testMode);
    check("txOutValid", 1'b0, txOutValid);
    check("txInReady", 1'b1, txInReady);
    @(posedge sys_clk);
    stall <= 1'b1;
    push(8'hA1, 1'b0, 1'b0, 1'b0);
    push(8'hA2, 1'b0, 1'b0, 1'b0);
    #1;
    check("txInReady", 1'b0, txInReady);
    check("txOut", 8'hA1, txOut.data);
    @(posedge sys_clk);
    stall <= 1'b0;
    push(8'hA3, 1'b1, 1'b0, 1'b0);
    strobe(0);
    check("wordCount", 8'h03, wordCount);
    check("lastData", 8'hA3, lastData);
    $display("buffer test done");
    foreach (gapTab[i])
    begin
      do_reset();
      @(posedge sys_clk);
      speed <= speed_t'(gapTab[i][0]);
      host_pkt(1'b0);
      push(8'h5A, 1'b1, 1'b0, 1'b0);
      strobe(gapTab[i][1] - 1);
      check("wordCount", 8'h00, wordCount);
      strobe(1);
      check("wordCount", 8'h01, wordCount);
    end
    $display("gap test done");
    foreach (lateTab[i])
    begin
      do_reset();
      @(posedge sys_clk);
      speed <= speed_t'(lateTab[i][0]);
      captiveCable <= (lateTab[i][1] != 0);
      host_pkt(1'b0);
      clr();
      strobe(lateTab[i][2]);
      push(8'hD2, 1'b1, 1'b0, 1'b1);
      strobe(0);
      check("rspLate", lateTab[i][3], lateCnt);
    end
    $display("late test done");
    foreach (toTab[i])
    begin
      do_reset();
      @(posedge sys_clk);
      speed <= speed_t'(toTab[i][0]);
      push(8'h69, 1'b1, 1'b1, 1'b0);
      strobe(0);
      clr();
      strobe(toTab[i][1]);
      check("rspTimeout", 0, toCnt);
      strobe(toTab[i][2]);
      check("rspTimeout", 1, toCnt);
    end
    $display("timeout test done");
    for (int s = 1; s <= 5; s++)
    begin
      do_reset();
      enter(test_sel_t'(s), s != 5, 1'b1);
      check("testMode", s, testMode);
      check("xcvrHsRx", s == 1, xcvrHsRx);
      check("driveJ", s == 2, driveJ);
      check("driveK", s == 3, driveK);
      check("portForceEn", s == 5, portForceEn);
      clr();
      host_pkt(1'b0);
      check("repeatEn", s == 5, repCnt);
      enter(test_sel_t'((s % 5) + 1), s != 5, 1'b1);
      check("testMode", s, testMode);
      @(posedge sys_clk);
      hubReset <= 1'b1;
      discIn <= s[0];
      @(posedge sys_clk);
      hubReset <= 1'b0;
      strobe(0);
      check("discFlag", s[0], discFlag);
      check("testMode", (s == 5) ? 0 : s, testMode);
    end
    do_reset();
    enter(TM_FORCE_EN, 1'b1, 1'b1);
    check("testMode", 0, testMode);
    enter(TM_J, 1'b1, 1'b0);
    check("testMode", 0, testMode);
    $display("mode test done");
    do_reset();
    enter(TM_PACKET, 1'b1, 1'b1);
    pktSr = 40'h00_0000_0000;
    strobe(40);
    check("pktBits", 40'h00_0000_01C3, pktSr);
    strobe(448);
    check("pktBits", 40'hBF_7E6D_737F, pktSr);
    strobe(48);
    check("pktBits", 40'h00_0000_01C3, pktSr);
    do_reset();
    @(posedge sys_clk);
    speed <= SPD_HS;
    enter(TM_SE0_NAK, 1'b1, 1'b1);
    host_pkt(1'b1);
    clr();
    strobe(7);
    check("nakReq", 0, nakCnt);
    strobe(1);
    check("nakReq", 1, nakCnt);
    $display("packet and nak test done");
    tally_and_finish();
  end
endmodule : tb_top
